// ---- rtl/spm_regs.svh ----
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: 8-bit registers on a byte-addressed register port
// Notes: included by spm package users
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
`define SPM_OFS_SYS_FLAGS 8'h10
`define SPM_OFS_GLB_EVENTS 8'h11
`define SPM_OFS_TEMP_FLAGS 8'h19
`define SPM_OFS_TEMP_LO 8'h1A
`define SPM_OFS_TEMP_HI 8'h1B
`define SPM_OFS_TEMP_RESEED 8'hC0
`define SPM_OFS_TEMP_CHMUL 8'hC1
`define SPM_OFS_TEMP_CALMUL 8'hC2
`define SPM_OFS_TEMP_CALDIV 8'hC3
`define SPM_OFS_TEMP_CALOFS 8'hC4
`define SPM_OFS_PWR_MODE 8'hD2
`define SPM_OFS_NRM_RATE 8'hD3
`define SPM_OFS_LP_RATE 8'hD4
`define SPM_OFS_ULP_RATE 8'hD5
`define SPM_OFS_MODE_TIMER 8'hD6
`define SPM_OFS_SYS_SET 8'hD0
`define SPM_BIT_SHOW_RESET 7
`define SPM_BIT_SYSTEM_EVENT_FLAG 5
`define SPM_BIT_TEMP_EVENT 4
`define SPM_BIT_TEMP_TRIP 7
`define SPM_BIT_SLOW_OSC 4
`define SPM_BIT_ACK_RESET 6
`define SPM_BIT_OTP_SLOW 2
`define SPM_BIT_ULP_EN 6
`define SPM_BIT_AUTO_DIS 5
`define SPM_RST_PWR_MODE 8'h00
`define SPM_RST_RATE 8'h10
`define SPM_RST_ULP_RATE 8'h08
`define SPM_RST_TIMER 8'h0A
`define SPM_CLK_MHZ 125
`define SPM_MS_CYC (`SPM_CLK_MHZ * 1000)
`define SPM_ULP_STEP_MS 16
`define SPM_MODE_STEP_MS 500
`endif

// ---- rtl/spm_pkg.sv ----
// Purpose: shared types for the power mode sequencer
// Assumes: nothing
// Notes: mode codes are fixed encodings of the mode field
package spm_pkg;
  typedef enum logic [1:0] {
    SPM_NORMAL = 2'b00,
    SPM_LOWPWR = 2'b01,
    SPM_ULP = 2'b10,
    SPM_HALT = 2'b11
  } spm_mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spm_req_t;
  typedef struct packed {
    logic ch0_prox;
    logic activation;
    logic temp_event;
    logic temp_trip;
    logic [15:0] temp_value;
  } spm_sense_t;
endpackage : spm_pkg

// ---- rtl/spm_ctrl.sv ----
// Purpose: power mode sequencer, report timers, reset and event flags
// Assumes: register port already decoded from the serial engine
// Notes: sense inputs are asynchronous and synchronised here
// Overview of operation
// R1: all logic runs from main oscillator, 16 MHz by default; the millisecond count assumes a 125 MHz clock
// R2: reduced speed gives 4 MHz; timers rescaled so intervals stay same; the millisecond count here uses one cycle count at both speeds
// R3: host writes settings bit 4 to select reduced oscillator speed
// R4: option bank bit 2 permanently forces reduced speed
// R5: four modes: normal, low power, ultra-low power, halt
// R6: host disables auto switching before entering or leaving halt
// R7: auto switching by default; disable bit holds mode field selection
// R8: normal mode senses every normal interval, 1 ms steps
// R9: low power mode senses every low power interval, 1 ms steps
// R10: low power senses all channels at reduced oscillator speed
// R11: ultra-low power senses channel 0; others on full update cycles
// R12: full update every 2^(n+1) ultra-low power intervals
// R13: ultra-low power used only when its enable bit is set; with auto switching disabled the mode field selects it without that bit
// R14: ultra-low power interval counts in 16 ms steps
// R15: channel 0 proximity in ultra-low power returns to normal
// R16: halt suspends sensing until host changes the mode
// R17: no activation within mode time steps to next slower mode
// R18: reset sets show-reset flag; host acknowledge bit clears it
// R19: system event flag stays raised until reset acknowledged
// R20: temperature event sets global events bit 4
// R21: temperature trip sets flags bit 7, other bits zero
// R22: die temperature read as low byte then high byte
// R23: mode codes normal 00, low power 01, ultra-low 10, halt 11
`timescale 1ns/100ps
`default_nettype none
`include "spm_regs.svh"
module spm_ctrl import spm_pkg::*; #(
  parameter int MS_CYCLES = `SPM_MS_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // register port
  input wire spm_req_t i_req,
  output logic [7:0] o_rdata,
  // option bank and sensing front end
  input wire logic i_otp_slow,
  input wire spm_sense_t i_sense,
  // sequencer outputs
  output spm_mode_t o_mode,
  output logic o_slow_osc,
  output logic o_sense_all,
  output logic o_sense_ch0
);
  localparam logic [31:0] MS_LIM = 32'(MS_CYCLES - 1);
  localparam logic [4:0] ULP_STEP = 5'(`SPM_ULP_STEP_MS);
  localparam logic [9:0] MODE_STEP = 10'(`SPM_MODE_STEP_MS);

  logic [7:0] pwr_r, nrm_r, lp_r, ulp_r, tmr_r;
  logic [7:0] reseed_r, chmul_r, calmul_r, caldiv_r, calofs_r;
  logic slow_sw_r, otp_slow_r, show_reset_r, temp_ev_r, temp_trip_r;
  logic [15:0] temp_r, temp_prev_r;
  spm_sense_t s1_r, s2_r;
  logic otp1_r;
  spm_mode_t mode_r, mode_nxt;
  logic [31:0] ms_cnt_r;
  logic ms_tick;
  logic [7:0] rate_cnt_r;
  logic [4:0] ulp_sub_r;
  logic [7:0] np_cnt_r;
  logic [9:0] step_ms_r;
  logic [7:0] idle_cnt_r;
  logic [7:0] rdata_nxt;
  logic ack_wr, sample, ulp_tick, mode_expire;

  // input synchronisers
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      otp1_r <= 1'b0;
      otp_slow_r <= 1'b0;
    end else begin
      s1_r <= i_sense;
      s2_r <= s1_r;
      otp1_r <= i_otp_slow;
      otp_slow_r <= otp1_r;
    end
  end

  assign ack_wr = i_req.wr && i_req.addr == `SPM_OFS_SYS_SET &&
    i_req.wdata[`SPM_BIT_ACK_RESET];

  // writable settings
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pwr_r <= `SPM_RST_PWR_MODE;
      nrm_r <= `SPM_RST_RATE;
      lp_r <= `SPM_RST_RATE;
      ulp_r <= `SPM_RST_ULP_RATE;
      tmr_r <= `SPM_RST_TIMER;
      slow_sw_r <= 1'b0;
      reseed_r <= 8'h00;
      chmul_r <= 8'h00;
      calmul_r <= 8'h00;
      caldiv_r <= 8'h00;
      calofs_r <= 8'h00;
    end else if (i_req.wr) begin
      unique case (i_req.addr)
        `SPM_OFS_SYS_SET: slow_sw_r <= i_req.wdata[`SPM_BIT_SLOW_OSC]; // R3
        `SPM_OFS_PWR_MODE: pwr_r <= i_req.wdata;
        `SPM_OFS_NRM_RATE: nrm_r <= i_req.wdata;
        `SPM_OFS_LP_RATE: lp_r <= i_req.wdata;
        `SPM_OFS_ULP_RATE: ulp_r <= i_req.wdata;
        `SPM_OFS_MODE_TIMER: tmr_r <= i_req.wdata;
        `SPM_OFS_TEMP_RESEED: reseed_r <= i_req.wdata;
        `SPM_OFS_TEMP_CHMUL: chmul_r <= i_req.wdata;
        `SPM_OFS_TEMP_CALMUL: calmul_r <= i_req.wdata;
        `SPM_OFS_TEMP_CALDIV: caldiv_r <= i_req.wdata;
        `SPM_OFS_TEMP_CALOFS: calofs_r <= i_req.wdata;
        default: ;
      endcase
    end
  end

  // reset indication, set wins over acknowledge
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      show_reset_r <= 1'b1; // R18
    end else if (ack_wr) begin
      show_reset_r <= 1'b0; // R18
    end
  end

  // temperature flags and value
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      temp_ev_r <= 1'b0;
      temp_trip_r <= 1'b0;
      temp_r <= 16'h0000;
      temp_prev_r <= 16'h0000;
    end else begin
      temp_ev_r <= s2_r.temp_event; // R20
      temp_trip_r <= s2_r.temp_trip; // R21
      temp_prev_r <= s2_r.temp_value;
      // word taken only once two samples agree
      if (s2_r.temp_value == temp_prev_r) begin
        temp_r <= s2_r.temp_value; // R22
      end
    end
  end

  // millisecond base, same MS_CYCLES count in either oscillator speed
  assign ms_tick = ms_cnt_r == MS_LIM; // R2
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || ms_tick) begin
      ms_cnt_r <= 32'h0000_0000;
    end else begin
      ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
    end
  end

  // 16 ms sub-step for ultra-low power
  assign ulp_tick = ms_tick && ulp_sub_r == ULP_STEP - 5'h01; // R14
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || ulp_tick) begin
      ulp_sub_r <= 5'h00;
    end else if (ms_tick) begin
      ulp_sub_r <= ulp_sub_r + 5'h01;
    end
  end

  // report interval counter
  function automatic logic [7:0] rate_of(spm_mode_t m);
    unique case (m)
      SPM_NORMAL: rate_of = nrm_r; // R8
      SPM_LOWPWR: rate_of = lp_r; // R9
      SPM_ULP: rate_of = ulp_r; // R14
      SPM_HALT: rate_of = 8'h00;
    endcase
  endfunction : rate_of

  assign sample = mode_r != SPM_HALT &&
    {1'b0, rate_cnt_r} + 9'h001 >= {1'b0, rate_of(mode_r)} && // R8 R9 R14
    (mode_r == SPM_ULP ? ulp_tick : ms_tick);
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || sample || mode_r != mode_nxt) begin
      rate_cnt_r <= 8'h00;
    end else if (mode_r == SPM_ULP ? ulp_tick : ms_tick) begin
      rate_cnt_r <= rate_cnt_r + 8'h01;
    end
  end

  // full update cycle divider
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || mode_r != SPM_ULP) begin
      np_cnt_r <= 8'h00;
    end else if (sample) begin
      np_cnt_r <= np_cnt_r + 8'h01; // R12
    end
  end

  // inactivity mode timer in 500 ms steps
  assign mode_expire = idle_cnt_r >= tmr_r && ms_tick &&
    step_ms_r == MODE_STEP - 10'h001;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || s2_r.activation || mode_r != mode_nxt ||
        (ms_tick && step_ms_r == MODE_STEP - 10'h001)) begin
      step_ms_r <= 10'h000;
    end else if (ms_tick) begin
      step_ms_r <= step_ms_r + 10'h001;
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || s2_r.activation || mode_r != mode_nxt) begin
      idle_cnt_r <= 8'h00; // R17
    end else if (ms_tick && step_ms_r == MODE_STEP - 10'h001) begin
      idle_cnt_r <= idle_cnt_r + 8'h01; // R17
    end
  end

  // mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    if (pwr_r[`SPM_BIT_AUTO_DIS]) begin
      mode_nxt = spm_mode_t'(pwr_r[4:3]); // R7 R16 R23
    end else begin
      unique case (mode_r)
        SPM_NORMAL: if (mode_expire) mode_nxt = SPM_LOWPWR; // R17
        SPM_LOWPWR: begin
          if (s2_r.activation) begin
            mode_nxt = SPM_NORMAL;
          end else if (mode_expire && pwr_r[`SPM_BIT_ULP_EN]) begin
            mode_nxt = SPM_ULP; // R13 R17
          end
        end
        SPM_ULP: begin
          if (s2_r.ch0_prox || !pwr_r[`SPM_BIT_ULP_EN]) begin
            mode_nxt = SPM_NORMAL; // R15
          end
        end
        SPM_HALT: mode_nxt = SPM_HALT; // R6 R16
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      mode_r <= SPM_NORMAL; // R5
    end else begin
      mode_r <= mode_nxt; // R5
    end
  end

  // sensing strobes and oscillator select
  function automatic logic np_due(logic [7:0] cnt, logic [2:0] sel);
    logic [7:0] msk;
    msk = 8'((9'h002 << sel) - 9'h001);
    np_due = (cnt & msk) == msk;
  endfunction : np_due

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_slow_osc <= 1'b0; // R1
      o_sense_all <= 1'b0;
      o_sense_ch0 <= 1'b0;
      o_mode <= SPM_NORMAL;
    end else begin
      o_slow_osc <= slow_sw_r || otp_slow_r || mode_r == SPM_LOWPWR; // R2 R3 R4 R10
      o_sense_ch0 <= sample; // R11
      o_sense_all <= sample && (mode_r != SPM_ULP ||
        np_due(np_cnt_r, pwr_r[2:0])); // R10 R11 R12
      o_mode <= mode_r;
    end
  end

  // register read
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (i_req.addr)
      `SPM_OFS_SYS_FLAGS: rdata_nxt[`SPM_BIT_SHOW_RESET] = show_reset_r; // R18
      `SPM_OFS_GLB_EVENTS: begin
        rdata_nxt[`SPM_BIT_SYSTEM_EVENT_FLAG] = show_reset_r; // R19
        rdata_nxt[`SPM_BIT_TEMP_EVENT] = temp_ev_r; // R20
      end
      `SPM_OFS_TEMP_FLAGS: rdata_nxt[`SPM_BIT_TEMP_TRIP] = temp_trip_r; // R21
      `SPM_OFS_TEMP_LO: rdata_nxt = temp_r[7:0]; // R22
      `SPM_OFS_TEMP_HI: rdata_nxt = temp_r[15:8]; // R22
      `SPM_OFS_SYS_SET: rdata_nxt[`SPM_BIT_SLOW_OSC] = slow_sw_r;
      `SPM_OFS_PWR_MODE: rdata_nxt = pwr_r;
      `SPM_OFS_NRM_RATE: rdata_nxt = nrm_r;
      `SPM_OFS_LP_RATE: rdata_nxt = lp_r;
      `SPM_OFS_ULP_RATE: rdata_nxt = ulp_r;
      `SPM_OFS_MODE_TIMER: rdata_nxt = tmr_r;
      `SPM_OFS_TEMP_RESEED: rdata_nxt = reseed_r;
      `SPM_OFS_TEMP_CHMUL: rdata_nxt = chmul_r;
      `SPM_OFS_TEMP_CALMUL: rdata_nxt = calmul_r;
      `SPM_OFS_TEMP_CALDIV: rdata_nxt = caldiv_r;
      `SPM_OFS_TEMP_CALOFS: rdata_nxt = calofs_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      o_rdata <= rdata_nxt;
    end
  end

  // checks
  property p_ack_clears;
    @(posedge i_clock) disable iff (!i_reset_n)
    ack_wr |=> !show_reset_r;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack failed"); // R18

  property p_halt_stays;
    @(posedge i_clock) disable iff (!i_reset_n)
    (mode_r == SPM_HALT && !pwr_r[`SPM_BIT_AUTO_DIS]) |=> mode_r == SPM_HALT;
  endproperty
  a_halt_stays: assert property (p_halt_stays) else $error("halt left"); // R16

  property p_halt_quiet;
    @(posedge i_clock) disable iff (!i_reset_n)
    mode_r == SPM_HALT |=> !o_sense_ch0;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("halt sensed"); // R16

  property p_fixed_mode;
    @(posedge i_clock) disable iff (!i_reset_n)
    pwr_r[`SPM_BIT_AUTO_DIS] |=> mode_r == spm_mode_t'($past(pwr_r[4:3]));
  endproperty
  a_fixed_mode: assert property (p_fixed_mode) else $error("fixed mode"); // R7

  property p_ulp_enable;
    @(posedge i_clock) disable iff (!i_reset_n)
    (!pwr_r[`SPM_BIT_AUTO_DIS] && !pwr_r[`SPM_BIT_ULP_EN]) |=>
      mode_r != SPM_ULP;
  endproperty
  a_ulp_enable: assert property (p_ulp_enable) else $error("ulp used"); // R13

  property p_wake;
    @(posedge i_clock) disable iff (!i_reset_n)
    (mode_r == SPM_ULP && s2_r.ch0_prox && !pwr_r[`SPM_BIT_AUTO_DIS]) |=>
      mode_r == SPM_NORMAL;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake"); // R15

  property p_slow;
    @(posedge i_clock) disable iff (!i_reset_n)
    (otp_slow_r || slow_sw_r) |=> o_slow_osc;
  endproperty
  a_slow: assert property (p_slow) else $error("osc not slow"); // R3

  property p_system_event_flag;
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_req.addr == `SPM_OFS_GLB_EVENTS && i_req.rd && show_reset_r) |=>
      o_rdata[`SPM_BIT_SYSTEM_EVENT_FLAG];
  endproperty
  a_system_event_flag: assert property (p_system_event_flag) else $error("system_event_flag"); // R19

  sequence s_idle_expired;
    mode_r == SPM_NORMAL && !pwr_r[`SPM_BIT_AUTO_DIS] && mode_expire;
  endsequence
  property p_step_down;
    @(posedge i_clock) disable iff (!i_reset_n)
    s_idle_expired |=> mode_r == SPM_LOWPWR;
  endproperty
  a_step_down: assert property (p_step_down) else $error("no step"); // R17

  property p_event_held;
    @(posedge i_clock) disable iff (!i_reset_n)
    (show_reset_r && !ack_wr) |=> show_reset_r;
  endproperty
  a_event_held: assert property (p_event_held) else $error("event lost"); // R19

  property p_ulp_part;
    @(posedge i_clock) disable iff (!i_reset_n)
    (sample && mode_r == SPM_ULP && !np_cnt_r[0]) |=>
      (o_sense_ch0 && !o_sense_all);
  endproperty
  a_ulp_part: assert property (p_ulp_part) else $error("ulp all"); // R11

  property p_trip;
    @(posedge i_clock) disable iff (!i_reset_n)
    s2_r.temp_trip |=> temp_trip_r;
  endproperty
  a_trip: assert property (p_trip) else $error("trip lost"); // R21

  property p_temp_ev;
    @(posedge i_clock) disable iff (!i_reset_n)
    s2_r.temp_event |=> temp_ev_r;
  endproperty
  a_temp_ev: assert property (p_temp_ev) else $error("temp event"); // R20
endmodule : spm_ctrl
`default_nettype wire

// ---- bench/spm_host_model.sv ----
// Purpose: host side of the register port
// Assumes: one request per call, launched at a falling edge
// Notes: idle address and data lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module spm_host_model import spm_pkg::*; (
  // clock
  input wire logic i_clock,
  // register port
  output spm_req_t o_req,
  input wire logic [7:0] i_rdata
);
  initial o_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(negedge i_clock);
    o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    @(negedge i_clock);
    d = i_rdata;
  endtask : read_reg
endmodule : spm_host_model
`default_nettype wire

// ---- bench/test_spm_ctrl.sv ----
// Purpose: self-checking bench for the power mode sequencer
// Assumes: timing base shortened to four cycles per millisecond
// Notes: inputs change at falling edges only
`timescale 1ns/100ps
`default_nettype none
module test_spm_ctrl import spm_pkg::*;;
  localparam int MS = 4;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_otp_slow = 1'b0;
  spm_sense_t i_sense = '0;
  spm_req_t req;
  logic [7:0] rdata;
  spm_mode_t mode;
  logic slow, s_all, s_ch0;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] ofs [10] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4,
                           8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6};
  logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h10, 8'h10, 8'h08, 8'h0A};
  always #4 i_clock = ~i_clock;
  spm_ctrl #(.MS_CYCLES(MS)) DUT (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_req(req), .o_rdata(rdata), .i_otp_slow(i_otp_slow),
    .i_sense(i_sense), .o_mode(mode), .o_slow_osc(slow),
    .o_sense_all(s_all), .o_sense_ch0(s_ch0));
  spm_host_model u_host (.i_clock(i_clock), .o_req(req), .i_rdata(rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.read_reg(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask : rd_chk
  task automatic wait_mode(input spm_mode_t m);
    int k;
    for (k = 0; k < 6000 && mode !== m; k++) @(negedge i_clock);
    check({14'h0000, mode}, {14'h0000, m});
  endtask : wait_mode
  // cycles between pulses, minus one, taken from the second to the third pulse
  task automatic gap(input logic ch0, output logic [15:0] n);
    int k;
    n = 16'h0000;
    for (k = 0; k < 3; k++) begin
      n = 16'h0000;
      @(negedge i_clock);
      while ((ch0 ? s_ch0 : s_all) !== 1'b1 && n < 16'h0FFF) begin
        n++;
        @(negedge i_clock);
      end
    end
  endtask : gap
  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    repeat (90000) @(posedge i_clock);
    err_total++;
    final_report();
  end
  initial begin
    logic [15:0] n;
    int i;
    repeat (16) @(negedge i_clock);
    i_reset_n = 1'b1;
    rd_chk(8'h10, 8'h80);
    rd_chk(8'h11, 8'h20);
    check({15'h0000, slow}, 16'h0000);
    rd_chk(8'hD0, 8'h00);
    u_host.write_reg(8'h10, 8'h00);
    rd_chk(8'h10, 8'h80);
    rd_chk(8'h55, 8'h00);
    for (i = 0; i < 10; i++) begin
      rd_chk(ofs[i], rstv[i]);
      u_host.write_reg(ofs[i], 8'hA5 ^ 8'(i));
      rd_chk(ofs[i], 8'hA5 ^ 8'(i));
    end
    u_host.write_reg(8'hD0, 8'h40);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'hD0, 8'h00);
    u_host.write_reg(8'hD0, 8'h10);
    rd_chk(8'hD0, 8'h10);
    check({15'h0000, slow}, 16'h0001);
    u_host.write_reg(8'hD3, 8'h02);
    u_host.write_reg(8'hD4, 8'h05);
    u_host.write_reg(8'hD5, 8'h01);
    u_host.write_reg(8'hD2, 8'h61);
    wait_mode(SPM_NORMAL);
    gap(1'b0, n);
    check(n, 16'(2 * MS - 1));
    u_host.write_reg(8'hD0, 8'h00);
    gap(1'b0, n);
    check(n, 16'(2 * MS - 1));
    check({15'h0000, slow}, 16'h0000);
    i_otp_slow = 1'b1;
    repeat (4) @(negedge i_clock);
    check({15'h0000, slow}, 16'h0001);
    i_otp_slow = 1'b0;
    u_host.write_reg(8'hD2, 8'h69);
    wait_mode(SPM_LOWPWR);
    check({15'h0000, slow}, 16'h0001);
    gap(1'b0, n);
    check(n, 16'(5 * MS - 1));
    u_host.write_reg(8'hD2, 8'h71);
    wait_mode(SPM_ULP);
    gap(1'b1, n);
    check(n, 16'(16 * MS - 1));
    gap(1'b0, n);
    check(n, 16'(64 * MS - 1));
    u_host.write_reg(8'hD2, 8'h79);
    wait_mode(SPM_HALT);
    n = 16'h0000;
    repeat (800) begin
      @(negedge i_clock);
      n = n + 16'(s_all | s_ch0);
    end
    check(n, 16'h0000);
    u_host.write_reg(8'hD2, 8'h61);
    wait_mode(SPM_NORMAL);
    i_sense.temp_event = 1'b1;
    i_sense.temp_trip = 1'b1;
    i_sense.temp_value = 16'h1234;
    repeat (4) @(negedge i_clock);
    rd_chk(8'h11, 8'h10);
    rd_chk(8'h19, 8'h80);
    rd_chk(8'h1A, 8'h34);
    rd_chk(8'h1B, 8'h12);
    i_sense = '0;
    repeat (4) @(negedge i_clock);
    rd_chk(8'h19, 8'h00);
    u_host.write_reg(8'hD6, 8'h00);
    u_host.write_reg(8'hD2, 8'h00);
    wait_mode(SPM_LOWPWR);
    repeat (6000) @(negedge i_clock);
    check({14'h0000, mode}, {14'h0000, SPM_LOWPWR});
    i_sense.activation = 1'b1;
    wait_mode(SPM_NORMAL);
    repeat (3000) @(negedge i_clock);
    check({14'h0000, mode}, {14'h0000, SPM_NORMAL});
    i_sense.activation = 1'b0;
    wait_mode(SPM_LOWPWR);
    u_host.write_reg(8'hD2, 8'h40);
    wait_mode(SPM_ULP);
    i_sense.ch0_prox = 1'b1;
    wait_mode(SPM_NORMAL);
    i_sense.ch0_prox = 1'b0;
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_reset_n = 1'b1;
    rd_chk(8'h10, 8'h80);
    rd_chk(8'hD2, 8'h00);
    final_report();
  end
endmodule : test_spm_ctrl
`default_nettype wire
